/* inc/pstab_pkg.sv */
// Shared constants and types of the program-space table-access block
package pstab_pkg;
    // Register indices; byte address is four times the index
    localparam logic [9:0] IDX_PC_LOW  = 10'h02e;
    localparam logic [9:0] IDX_PC_HIGH = 10'h030;
    localparam logic [9:0] IDX_PAGE   = 10'h032;
    localparam logic [9:0] IDX_TADDR  = 10'h040;
    localparam logic [9:0] IDX_TWDATA = 10'h041;
    localparam logic [9:0] IDX_TCMD   = 10'h042;
    localparam logic [9:0] IDX_TRDATA = 10'h043;
    localparam logic [9:0] IDX_TSTAT  = 10'h044;
    // Reset values
    localparam logic [15:0] PC_LOW_RST  = 16'h0000;
    localparam logic [7:0]  PC_HIGH_RST = 8'h00;
    localparam logic [7:0]  PAGE_RST = 8'h00;
    // Field positions
    localparam int CMD_GO    = 0;
    localparam int CMD_OP_LO = 1;
    localparam int CMD_BYTE  = 3;
    localparam int CMD_STEP  = 4;
    localparam int PAGE_CFG  = 7;
    localparam int ST_BUSY   = 0;
    localparam int ST_REFUSE = 1;
    localparam int ST_DONE   = 2;
    // Program counter step per 24-bit word
    localparam logic [23:0] PC_STEP = 24'h000002;
    // Flash array geometry
    localparam int MEM_AW = 8;
    localparam int WORD_W = 24;
    // Implemented configuration words (identification area)
    localparam logic [7:0] CFG_WORDS = 8'h04;
    // Table operations
    typedef enum logic [1:0] {
        OP_RD_LOW  = 2'h0,
        OP_WR_LOW  = 2'h1,
        OP_RD_HIGH = 2'h2,
        OP_WR_HIGH = 2'h3
    } tbl_op_t;
endpackage

/* inc/flash_if.sv */
// Carrier between the table controller and the program word array
interface flash_if;
    logic [pstab_pkg::MEM_AW-1:0] addr;  // Word index
    logic                         wen;   // Write strobe
    logic [2:0]                   lanes; // Byte lanes to write
    logic [23:0]                  wdata; // Write word
    logic [23:0]                  rdata; // Registered read word
    modport ctrl (output addr, output wen, output lanes, output wdata, input rdata);
    modport mem  (input addr, input wen, input lanes, input wdata, output rdata);
endinterface

/* core/program_word_memory.sv */
// Small 24-bit program word array with byte-lane writes
module program_word_memory (
    input  wire logic mclk,
    input  wire logic nrst,
    flash_if.mem      port
);
    import pstab_pkg::*;

    logic [WORD_W-1:0] words [0:(1<<MEM_AW)-1]; // Storage, not reset
    logic [WORD_W-1:0] next_rdata;              // Next read word

    // Read always sees the stored word
    always_comb begin
        next_rdata = words[port.addr];
    end

    // Lane writes and registered read data
    always_ff @(posedge mclk) begin
        if (!nrst) begin
            port.rdata <= '0;
        end else begin
            port.rdata <= next_rdata;
        end
        for (int i = 0; i < 3; i++) begin
            if (port.wen && port.lanes[i]) begin
                words[port.addr][i*8 +: 8] <= port.wdata[i*8 +: 8];
            end
        end
    end
endmodule // program_word_memory

/* core/program_space_table_access.sv */
// Table access path between the core and 24-bit program memory, APB slave
module program_space_table_access #(
    parameter logic [23:0] CFG_ID0 = 24'h00a5a5, // Arbitrary identity value
    parameter logic [23:0] CFG_ID1 = 24'h005a5a  // Arbitrary identity value
) (
    input  wire logic        mclk,
    input  wire logic        nrst,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr
);
    import pstab_pkg::*;

    // State of the access sequencer
    typedef enum logic [1:0] {S_IDLE, S_ACCESS, S_CAPTURE} seq_t;

    flash_if fl ();                  // Link to the word array

    // Software-visible state
    logic [15:0] pcLow;              // Program counter low word
    logic [7:0]  pcHigh;             // Program counter high byte
    logic [7:0]  page;               // Table page select
    logic [15:0] taddr;              // Effective address of the access
    logic [15:0] twdata;             // Data for table writes
    logic [15:0] trdata;             // Result of last table read
    logic        refused;            // Sticky: write to configuration space
    logic        done;               // Sticky: operation completed
    tbl_op_t     op;                 // Latched operation
    logic        byteMode;           // Latched byte mode
    seq_t        state;              // Sequencer state
    logic [31:0] rdReg;              // Registered APB read data
    logic        errReg;             // Registered APB error

    // Next values
    logic [15:0] next_pcLow;
    logic [7:0]  next_pcHigh;
    logic [7:0]  next_page;
    logic [15:0] next_taddr;
    logic [15:0] next_twdata;
    logic [15:0] next_trdata;
    logic        next_refused;
    logic        next_done;
    tbl_op_t     next_op;
    logic        next_byteMode;
    seq_t        next_state;
    logic [31:0] next_rdReg;
    logic        next_errReg;

    // Decoded bus strobes
    logic        wrStrobe;           // Write takes effect this edge
    logic        rdStrobe;           // Read sampled this edge
    logic [9:0]  index;              // Word index of the register
    logic        cfgSpace;           // Page lies in configuration space
    logic        byteSel;            // Byte select of the access
    logic [23:0] pcNext;             // Counter after one word step
    logic [15:0] readValue;          // Value formatted for the core
    logic        userHit;            // Access lands in the implemented array

    // Known register index check, used by the error decode of reads and writes
    function automatic logic known(input logic [9:0] idx);
        return idx == IDX_PC_LOW || idx == IDX_PC_HIGH || idx == IDX_PAGE
            || idx == IDX_TADDR || idx == IDX_TWDATA || idx == IDX_TCMD
            || idx == IDX_TRDATA || idx == IDX_TSTAT;
    endfunction

    // Byte pick from a 16-bit word, used by both read paths
    function automatic logic [7:0] pick(input logic [15:0] w, input logic sel);
        return sel ? w[15:8] : w[7:0];
    endfunction

    // Zero-wait slave: the access phase completes on its first edge.
    // Read data and error are registered at the setup edge, so they
    // already stand in the access phase; the price is a snapshot.
    // Misaligned writes never reach a register
    assign pready   = 1'b1;
    assign wrStrobe = psel && penable && pwrite && paddr[1:0] == 2'h0;
    assign rdStrobe = psel && !penable && !pwrite;
    assign index    = paddr[11:2];
    assign prdata   = rdReg;
    assign pslverr  = errReg;

    assign cfgSpace = page[PAGE_CFG];
    assign byteSel  = taddr[0];
    assign pcNext   = {pcHigh, pcLow} + PC_STEP;
    // Only page zero of user space is implemented here
    assign userHit  = !cfgSpace && (page == PAGE_RST);

    // Word array addressing; word index is the address over two
    always_comb begin
        fl.addr  = taddr[MEM_AW:1];
        fl.wen   = 1'b0;
        fl.lanes = 3'h0;
        fl.wdata = {twdata[7:0], twdata};
        if (state == S_ACCESS && userHit) begin
            case (op)
                OP_WR_LOW: begin
                    fl.wen = 1'b1;
                    if (byteMode) begin
                        fl.lanes = byteSel ? 3'h2 : 3'h1;
                        fl.wdata = {8'h00, twdata[7:0], twdata[7:0]};
                    end else begin
                        fl.lanes = 3'h3;
                    end
                end
                OP_WR_HIGH: begin
                    // Phantom byte write has nowhere to go
                    fl.wen   = !(byteMode && byteSel);
                    fl.lanes = 3'h4;
                end
                default: begin
                    fl.wen = 1'b0;
                end
            endcase
        end
    end

    // Read formatting of the fetched word
    always_comb begin
        logic [23:0] word;
        word = 24'h000000;
        if (cfgSpace) begin
            // Configuration space: implemented identity words only
            if (taddr[8:1] == 8'h00) begin
                word = CFG_ID0;
            end else if (taddr[8:1] == 8'h01) begin
                word = CFG_ID1;
            end else if (taddr[8:1] < CFG_WORDS) begin
                word = 24'h000000;
            end
        end else if (userHit) begin
            word = fl.rdata;
        end
        if (op == OP_RD_HIGH) begin
            if (byteMode) begin
                // Phantom upper byte always reads zero
                readValue = {8'h00, pick({8'h00, word[23:16]}, byteSel)};
            end else begin
                readValue = {8'h00, word[23:16]};
            end
        end else begin
            if (byteMode) begin
                readValue = {8'h00, pick(word[15:0], byteSel)};
            end else begin
                readValue = word[15:0];
            end
        end
    end

    // Register writes, sequencer and read mux
    always_comb begin
        next_pcLow    = pcLow;
        next_pcHigh   = pcHigh;
        next_page     = page;
        next_taddr    = taddr;
        next_twdata   = twdata;
        next_trdata   = trdata;
        next_refused  = refused;
        next_done     = done;
        next_op       = op;
        next_byteMode = byteMode;
        next_state    = state;
        next_rdReg    = rdReg;
        next_errReg   = 1'b0;

        // Bus writes; refused and done status bits clear by writing one, busy does not
        if (wrStrobe) begin
            case (index)
                IDX_PC_LOW:  next_pcLow  = {pwdata[15:1], 1'b0};
                IDX_PC_HIGH: next_pcHigh = pwdata[7:0];
                IDX_PAGE:   next_page   = pwdata[7:0];
                IDX_TADDR:  next_taddr  = pwdata[15:0];
                IDX_TWDATA: next_twdata = pwdata[15:0];
                IDX_TSTAT: begin
                    if (pwdata[ST_REFUSE]) begin
                        next_refused = 1'b0;
                    end
                    if (pwdata[ST_DONE]) begin
                        next_done = 1'b0;
                    end
                end
                IDX_TCMD: begin
                    if (pwdata[CMD_STEP]) begin
                        next_pcLow  = pcNext[15:0];
                        next_pcHigh = pcNext[23:16];
                    end
                    // A start while busy is dropped
                    if (pwdata[CMD_GO] && state == S_IDLE) begin
                        next_op       = tbl_op_t'(pwdata[CMD_OP_LO +: 2]);
                        next_byteMode = pwdata[CMD_BYTE];
                        next_state    = S_ACCESS;
                    end
                end
                default: next_errReg = 1'b0;   // Unmapped write is dropped
            endcase
        end

        // Sequencer
        case (state)
            S_IDLE: begin
            end
            S_ACCESS: begin
                if ((op == OP_WR_LOW || op == OP_WR_HIGH) && cfgSpace) begin
                    next_refused = 1'b1;
                    next_state   = S_IDLE;
                end else if (op == OP_WR_LOW || op == OP_WR_HIGH) begin
                    next_done  = 1'b1;
                    next_state = S_IDLE;
                end else begin
                    next_state = S_CAPTURE;
                end
            end
            S_CAPTURE: begin
                next_trdata = readValue;
                next_done   = 1'b1;
                next_state  = S_IDLE;
            end
            default: next_state = S_IDLE;
        endcase

        // Error decided at the setup edge, so it stands through the access phase
        if (psel && !penable) begin
            next_errReg = !known(index) || paddr[1:0] != 2'h0;
        end

        // Bus reads snapshot at the setup edge; unmapped or misaligned answer zero
        if (rdStrobe) begin
            next_rdReg  = 32'h00000000;
            if (paddr[1:0] == 2'h0) begin
                case (index)
                    IDX_PC_LOW:  next_rdReg = {16'h0000, pcLow};
                    IDX_PC_HIGH: next_rdReg = {24'h000000, pcHigh};
                    IDX_PAGE:   next_rdReg = {24'h000000, page};
                    IDX_TADDR:  next_rdReg = {16'h0000, taddr};
                    IDX_TWDATA: next_rdReg = {16'h0000, twdata};
                    IDX_TCMD:   next_rdReg = {30'h00000000, op};
                    IDX_TRDATA: next_rdReg = {16'h0000, trdata};
                    IDX_TSTAT:  next_rdReg = {29'h00000000, done, refused, state != S_IDLE};
                    default:    next_rdReg = 32'h00000000;
                endcase
            end
        end
    end

    // State registers
    always_ff @(posedge mclk) begin
        if (!nrst) begin
            pcLow    <= PC_LOW_RST;
            pcHigh   <= PC_HIGH_RST;
            page     <= PAGE_RST;
            taddr    <= 16'h0000;
            twdata   <= 16'h0000;
            trdata   <= 16'h0000;
            refused  <= 1'b0;
            done     <= 1'b0;
            op       <= OP_RD_LOW;
            byteMode <= 1'b0;
            state    <= S_IDLE;
            rdReg    <= 32'h00000000;
            errReg   <= 1'b0;
        end else begin
            pcLow    <= next_pcLow;
            pcHigh   <= next_pcHigh;
            page     <= next_page;
            taddr    <= next_taddr;
            twdata   <= next_twdata;
            trdata   <= next_trdata;
            refused  <= next_refused;
            done     <= next_done;
            op       <= next_op;
            byteMode <= next_byteMode;
            state    <= next_state;
            rdReg    <= next_rdReg;
            errReg   <= next_errReg;
        end
    end

    // Program word array
    program_word_memory u_mem (
        .mclk (mclk),
        .nrst (nrst),
        .port (fl.mem)
    );
endmodule // program_space_table_access

/* dv/pstab_mem_model.sv */
// Reference image of the program word array, as the far side should hold it
module pstab_mem_model;
    timeunit 1ns;
    timeprecision 1ps;
    import pstab_pkg::*;
    logic [23:0] img [0:255]; // Expected 24-bit words, user page 0 only

    // Word writes: low ops own bits 15:0, high ops own bits 23:16
    task automatic put(input logic [7:0] idx, input tbl_op_t op, input logic [15:0] d);
        if (op == OP_WR_LOW) begin
            img[idx][15:0] = d;
        end else if (op == OP_WR_HIGH) begin
            img[idx][23:16] = d[7:0];
        end
    endtask

    // Expected destination value of a read
    function automatic logic [31:0] get(input logic [7:0] idx, input tbl_op_t op, input logic bm, input logic bs);
        logic [23:0] w;
        w = img[idx];
        if (op == OP_RD_LOW) begin
            get = bm ? {24'h0, bs ? w[15:8] : w[7:0]} : {16'h0, w[15:0]};
        end else begin
            // Phantom byte always zero, also when selected
            get = (bm && bs) ? 32'h0 : {24'h0, w[23:16]};
        end
    endfunction
endmodule // pstab_mem_model

/* dv/pstab_sva.sv */
// Port-level checker for the table access block
module pstab_sva
    import pstab_pkg::*;
(
    input wire logic        mclk,
    input wire logic        nrst,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!nrst);
    logic       mapped;       // Address hits a register
    logic [2:0] lastCmd;      // Byte flag and op of last command
    logic       lastSel;      // Byte select of last address
    logic [2:0] next_lastCmd; // Next command image
    logic       next_lastSel; // Next select image

    // Decode of the register map
    always_comb begin
        mapped = paddr inside {{IDX_PC_LOW, 2'b00}, {IDX_PC_HIGH, 2'b00}, {IDX_PAGE, 2'b00}, {IDX_TADDR, 2'b00},
                 {IDX_TWDATA, 2'b00}, {IDX_TCMD, 2'b00}, {IDX_TRDATA, 2'b00}, {IDX_TSTAT, 2'b00}};
        next_lastCmd = lastCmd;
        next_lastSel = lastSel;
        // Only completed write accesses count
        if (psel && penable && pwrite && paddr == {IDX_TCMD, 2'b00}) begin
            next_lastCmd = pwdata[3:1];
        end
        if (psel && penable && pwrite && paddr == {IDX_TADDR, 2'b00}) begin
            next_lastSel = pwdata[0];
        end
    end

    // Images of the last command and address
    always_ff @(posedge mclk) begin
        if (!nrst) begin
            lastCmd <= 3'h0;
            lastSel <= 1'b0;
        end else begin
            lastCmd <= next_lastCmd;
            lastSel <= next_lastSel;
        end
    end

    sequence s_acc;
        psel && penable;
    endsequence
    sequence s_rd(logic [11:0] a);
        psel && penable && !pwrite && paddr == a;
    endsequence

    property p_ready; pready; endproperty
    a_ready: assert property (p_ready) else $error("pready dropped");
    property p_err_pulse; pslverr |=> !pslverr; endproperty
    a_err_pulse: assert property (p_err_pulse) else $error("pslverr longer than one cycle");
    property p_err_map; s_acc ##0 !mapped |-> pslverr; endproperty
    a_err_map: assert property (p_err_map) else $error("unmapped access not flagged");
    property p_ok_map; s_acc ##0 mapped |-> !pslverr; endproperty
    a_ok_map: assert property (p_ok_map) else $error("mapped access flagged");
    property p_unm_zero; psel && penable && !pwrite && !mapped |-> prdata == 32'h0; endproperty
    a_unm_zero: assert property (p_unm_zero) else $error("unmapped read not zero");
    property p_pc_even; s_rd({IDX_PC_LOW, 2'b00}) |-> !prdata[0]; endproperty
    a_pc_even: assert property (p_pc_even) else $error("program counter odd");
    property p_page_w; s_rd({IDX_PAGE, 2'b00}) |-> prdata[31:8] == 24'h0; endproperty
    a_page_w: assert property (p_page_w) else $error("page register too wide");
    property p_hi_zero; s_rd({IDX_TRDATA, 2'b00}) ##0 lastCmd[1:0] == 2'h2 |-> prdata[31:8] == 24'h0; endproperty
    a_hi_zero: assert property (p_hi_zero) else $error("high read upper byte set");
    property p_hi_sel; s_rd({IDX_TRDATA, 2'b00}) ##0 (lastCmd == 3'h6 && lastSel) |-> prdata == 32'h0; endproperty
    a_hi_sel: assert property (p_hi_sel) else $error("phantom byte not zero");
    property p_lo_byte; s_rd({IDX_TRDATA, 2'b00}) ##0 lastCmd == 3'h4 |-> prdata[31:8] == 24'h0; endproperty
    a_lo_byte: assert property (p_lo_byte) else $error("byte read wider than a byte");
    property p_reset;
        @(posedge mclk) disable iff (1'b0) !nrst |=> prdata == 32'h0 && !pslverr;
    endproperty
    a_reset: assert property (p_reset) else $error("outputs not cleared by reset");
endmodule // pstab_sva

bind program_space_table_access pstab_sva u_pstab_sva (.mclk(mclk), .nrst(nrst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));

/* dv/program_space_table_access_tb_top.sv */
// Self-checking bench: APB register and table operations
module program_space_table_access_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import pstab_pkg::*;
    localparam logic [23:0] ID0 = 24'h3c5a69; // Arbitrary identity value
    localparam logic [23:0] ID1 = 24'h71e2d4; // Arbitrary identity value
    logic        mclk, nrst, psel, penable, pwrite, pready, pslverr; // Bus and clocking
    logic [11:0] paddr;          // Byte address
    logic [31:0] pwdata, prdata; // Data lanes
    logic [31:0] rd, st;         // Results
    int          errCount, samplesChecked;
    program_space_table_access #(.CFG_ID0(ID0), .CFG_ID1(ID1)) u_program_space_table_access (.mclk(mclk),
        .nrst(nrst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr));
    pstab_mem_model u_pstab_mem_model ();

    // Clock of 40 ns
    initial begin
        mclk = 1'b0;
        forever #20 mclk = ~mclk;
    end

    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        samplesChecked++;
        if (g !== e) begin
            errCount++;
            $display("BAD %s expected %h seen %h", n, e, g);
        end
    endtask

    // One APB transfer; data taken at the ready edge, then an idle edge
    task automatic apb(input logic w, input logic [9:0] idx, input logic [31:0] d, output logic [31:0] r);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= {idx, 2'b00};
        pwdata  <= d;
        @(posedge mclk);
        penable <= 1'b1;
        do @(posedge mclk); while (pready !== 1'b1);
        // Read before this edge's updates land: access-phase values
        r = prdata;
        if (pslverr === 1'b1) r = 32'hdead0000 | r;
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge mclk);
    endtask

    // Full table operation: address, command with go, poll, clear, fetch
    task automatic tbl(input logic [15:0] ta, input tbl_op_t op, input logic bm, stp);
        int n;
        apb(1'b1, IDX_TADDR, {16'h0, ta}, rd);
        apb(1'b1, IDX_TCMD, {27'h0, stp, bm, op, 1'b1}, rd);
        n = 0;
        do begin
            apb(1'b0, IDX_TSTAT, 32'h0, st);
            n++;
        end while (st[2:1] === 2'b00 && n < 20);
        // A poll limit that runs out counts as a mismatch
        chk("table op finished", 32'h1, {31'h0, |st[2:1]});
        apb(1'b1, IDX_TSTAT, 32'h6, rd);
        apb(1'b0, IDX_TRDATA, 32'h0, rd);
    endtask

    task automatic printVerdict();
        $display("checks %0d mismatches %0d", samplesChecked, errCount);
        if (errCount == 0 && samplesChecked > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask

    // Watchdog well beyond the expected run
    initial begin
        #(40 * 20000);
        errCount++;
        printVerdict();
    end

    // Main sequence
    initial begin
        errCount = 0; samplesChecked = 0;
        nrst = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 12'h0; pwdata = 32'h0;
        repeat (4) @(posedge mclk);
        nrst <= 1'b1;
        @(posedge mclk);
        // Reset values of the counter and page registers, then an unmapped read
        apb(1'b0, IDX_PC_LOW, 32'h0, rd);
        chk("counter low reset", {16'h0, PC_LOW_RST}, rd);
        apb(1'b0, IDX_PC_HIGH, 32'h0, rd);
        chk("counter high reset", {24'h0, PC_HIGH_RST}, rd);
        apb(1'b0, IDX_PAGE, 32'h0, rd);
        chk("page reset", {24'h0, PAGE_RST}, rd);
        apb(1'b0, 10'h3ff, 32'h0, rd);
        chk("unmapped read", 32'hdead0000, rd);
        // Word writes, then a second low write that must spare the high byte
        apb(1'b1, IDX_TWDATA, 32'h1234, rd);
        tbl(16'h0010, OP_WR_LOW, 1'b0, 1'b0);
        u_pstab_mem_model.put(8'h08, OP_WR_LOW, 16'h1234);
        apb(1'b1, IDX_TWDATA, 32'h00ab, rd);
        tbl(16'h0010, OP_WR_HIGH, 1'b0, 1'b0);
        u_pstab_mem_model.put(8'h08, OP_WR_HIGH, 16'h00ab);
        apb(1'b1, IDX_TWDATA, 32'hc65d, rd);
        tbl(16'h0010, OP_WR_LOW, 1'b0, 1'b0);
        u_pstab_mem_model.put(8'h08, OP_WR_LOW, 16'hc65d);
        // Every read mode and byte select
        for (int k = 0; k < 8; k++) begin
            tbl(16'h0010 | k[0], k[2] ? OP_RD_HIGH : OP_RD_LOW, k[1], 1'b0);
            chk("table read", u_pstab_mem_model.get(8'h08, k[2] ? OP_RD_HIGH : OP_RD_LOW, k[1], k[0]), rd);
        end
        // Byte writes: select one lands in bits 15:8, phantom high byte write is lost
        apb(1'b1, IDX_TWDATA, 32'h0077, rd);
        tbl(16'h0011, OP_WR_LOW, 1'b1, 1'b0);
        u_pstab_mem_model.img[8'h08][15:8] = 8'h77;
        apb(1'b1, IDX_TWDATA, 32'h00ee, rd);
        tbl(16'h0011, OP_WR_HIGH, 1'b1, 1'b0);
        tbl(16'h0010, OP_RD_LOW, 1'b0, 1'b0);
        chk("byte write low", u_pstab_mem_model.get(8'h08, OP_RD_LOW, 1'b0, 1'b0), rd);
        tbl(16'h0010, OP_RD_HIGH, 1'b0, 1'b0);
        chk("phantom byte write", u_pstab_mem_model.get(8'h08, OP_RD_HIGH, 1'b0, 1'b0), rd);
        // One step of the counter
        tbl(16'h0010, OP_RD_LOW, 1'b0, 1'b1);
        apb(1'b0, IDX_PC_LOW, 32'h0, rd);
        chk("counter step", 32'h2, rd);
        // Another user page is empty
        apb(1'b1, IDX_PAGE, 32'h01, rd);
        tbl(16'h0010, OP_RD_LOW, 1'b0, 1'b0);
        chk("other page", 32'h0, rd);
        // Configuration space: identity reads, writes refused
        apb(1'b1, IDX_PAGE, 32'h80, rd);
        tbl(16'h0000, OP_RD_LOW, 1'b0, 1'b0);
        chk("config low", {16'h0, ID0[15:0]}, rd);
        tbl(16'h0002, OP_RD_HIGH, 1'b0, 1'b0);
        chk("config high", {24'h0, ID1[23:16]}, rd);
        apb(1'b1, IDX_TWDATA, 32'hffff, rd);
        tbl(16'h0000, OP_WR_LOW, 1'b0, 1'b0);
        chk("refused flag", 32'h1, {31'h0, st[1]});
        tbl(16'h0000, OP_RD_LOW, 1'b0, 1'b0);
        chk("config kept", {16'h0, ID0[15:0]}, rd);
        printVerdict();
    end
endmodule // program_space_table_access_tb_top
